// ### hw/dka_access.sv
// Key access layer of a single-wire debug port: keys, information block,
// reset request, lock gating, user row window and sync edge event.
// Assumes the link layer hands over decoded bytes and takes answer bytes with
// the number of idle bits to place ahead of each; all inputs are synchronous.
`timescale 1ns/100ps
module dka_access
  import dka_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Key instruction bytes from the link layer.
  input  wire logic        key_start_i,
  input  wire logic        key_byte_valid_i,
  input  wire logic [7:0]  key_byte_i,
  input  wire logic        info_req_i,
  input  wire logic        info_full_i,
  // Answer bytes toward the link layer.
  output logic             tx_valid_o,
  output logic [7:0]       tx_byte_o,
  output logic [2:0]       tx_gap_bits_o,
  input  wire logic        tx_ready_i,
  output logic             interbyte_delay_enable_o,
  // Sync character edges.
  input  wire logic        sync_rise_i,
  output logic             sync_event_o,
  // System side.
  input  wire logic        lock_i,
  input  wire logic        insleep_i,
  input  wire logic        erase_done_i,
  input  wire logic [2:0]  brownout_fuse_level_i,
  input  wire logic        row_copy_done_i,
  output logic             sys_reset_o,
  output logic             erase_start_o,
  output logic             brownout_force_o,
  output logic [2:0]       brownout_level_o,
  output logic             sysbus_allow_o,
  output logic             nvm_direct_en_o,
  output logic             row_copy_req_o,
  output logic             clkreq_o,
  // RAM access filter for user row mode.
  input  wire logic        ram_wr_req_i,
  input  wire logic [15:0] ram_wr_addr_i,
  input  wire logic [7:0]  ram_wr_data_i,
  output logic             ram_wr_o,
  output logic [15:0]      ram_wr_addr_o,
  output logic [7:0]       ram_wr_data_o,
  output logic             ram_rd_block_o
);

  // State registers.
  logic [7:0]    control_r;
  logic          clkreq_r;
  logic          erase_key_r;
  logic          prog_key_r;
  logic          row_key_r;
  logic          erase_busy_r;
  logic          prog_ready_r;
  logic          row_ready_r;
  logic          row_finish_r;
  logic [63:0]   key_shift_r;
  logic [2:0]    key_count_r;
  logic          key_busy_r;
  dka_tx_state_t tx_state_r;
  logic [4:0]    tx_index_r;
  logic [4:0]    tx_len_r;

  // Bus decode.
  logic wb_req;
  logic wb_wr;
  logic wr_control;
  logic wr_key_status;
  logic wr_reset_req;
  logic wr_sys_ctrl;
  // Gating on the pending ack keeps a held request from being taken twice.
  assign wb_req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr         = wb_req && wb_we_i && wb_sel_i[0];
  assign wr_control    = wb_wr && (wb_adr_i == DKA_IDX_CONTROL);
  assign wr_key_status = wb_wr && (wb_adr_i == DKA_IDX_KEY_STATUS);
  assign wr_reset_req  = wb_wr && (wb_adr_i == DKA_IDX_RESET_REQ);
  assign wr_sys_ctrl   = wb_wr && (wb_adr_i == DKA_IDX_SYS_CTRL);

  // Reset request decode: signature asserts, zero releases, others ignored.
  // A release counts only while the reset is asserted, so a stray zero write
  // cannot enter a programming mode without a reset pulse before it.
  logic rst_assert;
  logic rst_release;
  assign rst_assert  = wr_reset_req && (wb_dat_i[7:0] == DKA_RESET_SIGNATURE);
  assign rst_release = wr_reset_req && (wb_dat_i[7:0] == DKA_RESET_RELEASE) && sys_reset_o;

  // Key compare on the eighth byte; the new byte enters at the top.
  // The compare looks at the incoming byte directly, so the key status changes
  // at the edge of the eighth byte with no extra cycle of latency.
  logic        key_last;
  logic [63:0] key_full;
  logic        hit_erase;
  logic        hit_prog;
  logic        hit_row;
  assign key_last  = key_busy_r && key_byte_valid_i && (key_count_r == DKA_KEY_LAST);
  assign key_full  = {key_byte_i, key_shift_r[63:8]};
  assign hit_erase = key_last && (key_full == DKA_SIG_ERASE);
  assign hit_prog  = key_last && (key_full == DKA_SIG_PROG);
  assign hit_row   = key_last && (key_full == DKA_SIG_ROW);

  // Register read data.
  // Unmapped indices read as zero; the reset request register is write-only.
  logic [7:0] key_status;
  logic [7:0] sys_ctrl;
  logic [7:0] sys_status;
  logic [7:0] rd_byte;
  assign key_status = ({7'h00, row_key_r} << DKA_KEY_ROW_BIT)
                    | ({7'h00, prog_key_r} << DKA_KEY_PROG_BIT)
                    | ({7'h00, erase_key_r} << DKA_KEY_ERASE_BIT);
  assign sys_ctrl   = ({7'h00, row_finish_r} << DKA_SCTL_FINISH_BIT)
                    | ({7'h00, clkreq_r} << DKA_SCTL_CLKREQ_BIT);
  assign sys_status = ({7'h00, sys_reset_o} << DKA_SST_RSTSYS_BIT)
                    | ({7'h00, insleep_i} << DKA_SST_INSLEEP_BIT)
                    | ({7'h00, prog_ready_r} << DKA_SST_PROGRDY_BIT)
                    | ({7'h00, row_ready_r} << DKA_SST_ROWRDY_BIT)
                    | ({7'h00, lock_i} << DKA_SST_LOCK_BIT);
  assign rd_byte = (wb_adr_i == DKA_IDX_CONTROL)    ? control_r :
                   (wb_adr_i == DKA_IDX_KEY_STATUS) ? key_status :
                   (wb_adr_i == DKA_IDX_SYS_CTRL)   ? sys_ctrl :
                   (wb_adr_i == DKA_IDX_SYS_STATUS) ? sys_status : 8'h00;

  // Information block sender decode.
  // The gap is picked when the next byte is loaded, so a change of the delay
  // option never alters a byte that is already on offer.
  logic       tx_take;
  logic       tx_done;
  logic       info_start;
  logic [2:0] gap_next;
  assign tx_take    = tx_valid_o && tx_ready_i;
  assign tx_done    = tx_take && (tx_index_r == tx_len_r);
  assign info_start = info_req_i && (tx_state_r == DKA_TX_IDLE);
  assign gap_next   = control_r[DKA_CTL_DELAY_BIT] ? (DKA_GAP_NORMAL + DKA_GAP_EXTRA)
                                                   : DKA_GAP_NORMAL;

  // Row window check on RAM writes.
  // Outside row mode every address passes; the window only narrows row writes.
  logic row_wr_ok;
  assign row_wr_ok = !row_ready_r || (ram_wr_addr_i < DKA_ROW_BYTES);

  // Wishbone answer: one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // Control register and clock request bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_r <= DKA_CONTROL_RST;
      clkreq_r  <= DKA_CLKREQ_RST;
    end else begin
      if (wr_control) begin
        control_r <= wb_dat_i[7:0];
      end
      if (wr_sys_ctrl) begin
        clkreq_r <= wb_dat_i[DKA_SCTL_CLKREQ_BIT];
      end
    end
  end

  // Key byte collector; no answer is produced for key bytes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_shift_r <= 64'h0000000000000000;
      key_count_r <= 3'h0;
      key_busy_r  <= 1'b0;
    end else if (key_start_i) begin
      key_count_r <= 3'h0;
      key_busy_r  <= 1'b1;
    end else if (key_busy_r && key_byte_valid_i) begin
      key_shift_r <= key_full;
      key_count_r <= key_count_r + 3'h1;
      key_busy_r  <= !key_last;
    end
  end

  // Key status bits; a mismatch leaves them as they are.
  // A set wins over a clear in the same cycle, so a key that arrives together
  // with a clearing write is not lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      erase_key_r <= 1'b0;
      prog_key_r  <= 1'b0;
      row_key_r   <= 1'b0;
    end else begin
      if (hit_erase) begin
        erase_key_r <= 1'b1;
      end
      if (hit_prog && !lock_i) begin
        prog_key_r <= 1'b1;
      end else if (prog_ready_r && rst_assert) begin
        prog_key_r <= 1'b0; // Programming done at the closing reset.
      end
      if (hit_row) begin
        row_key_r <= 1'b1;
      end else if (wr_key_status && wb_dat_i[DKA_KEY_ROW_BIT]) begin
        row_key_r <= 1'b0;
      end
    end
  end

  // System reset, erase and brown-out forcing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o   <= 1'b0;
      erase_start_o <= 1'b0;
      erase_busy_r  <= 1'b0;
      brownout_force_o <= 1'b0;
      brownout_level_o <= 3'h0;
    end else begin
      if (rst_assert) begin
        sys_reset_o <= 1'b1;
      end else if (rst_release) begin
        sys_reset_o <= 1'b0;
      end
      // The erase pulse is held back while an erase runs, so a repeated erase
      // key does not restart the memory controller in the middle of an erase.
      erase_start_o <= hit_erase && !erase_busy_r;
      if (hit_erase) begin
        erase_busy_r <= 1'b1;
      end else if (erase_done_i) begin
        erase_busy_r <= 1'b0;
      end
      brownout_force_o <= erase_busy_r || hit_erase;
      brownout_level_o <= brownout_fuse_level_i;
    end
  end

  // Programming and row modes; entered when the system reset is released.
  // The ready flags are sampled at the release write, because the system only
  // takes up a programming or row mode as it leaves reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_ready_r   <= 1'b0;
      row_ready_r    <= 1'b0;
      row_finish_r   <= 1'b0;
      row_copy_req_o <= 1'b0;
    end else begin
      if (rst_release && prog_key_r && !lock_i) begin
        prog_ready_r <= 1'b1;
      end else if (rst_assert || !prog_key_r) begin
        prog_ready_r <= 1'b0;
      end
      if (rst_release && row_key_r && lock_i) begin
        row_ready_r <= 1'b1;
      end else if (row_copy_done_i && row_finish_r) begin
        row_ready_r <= 1'b0;
      end
      if (wr_sys_ctrl && wb_dat_i[DKA_SCTL_FINISH_BIT] && row_ready_r) begin
        row_finish_r <= 1'b1;
      end else if (row_copy_done_i) begin
        row_finish_r <= 1'b0;
      end
      row_copy_req_o <= wr_sys_ctrl && wb_dat_i[DKA_SCTL_FINISH_BIT] && row_ready_r;
    end
  end

  // Access gating toward system bus, memory controller and RAM.
  // The RAM write path has one register stage so that the filtered strobe,
  // the address and the data leave together in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sysbus_allow_o  <= 1'b0;
      nvm_direct_en_o <= 1'b0;
      ram_rd_block_o  <= 1'b0;
      ram_wr_o        <= 1'b0;
      ram_wr_addr_o   <= 16'h0000;
      ram_wr_data_o   <= 8'h00;
      clkreq_o        <= DKA_CLKREQ_RST;
    end else begin
      sysbus_allow_o  <= !lock_i || row_ready_r;
      nvm_direct_en_o <= !lock_i && prog_ready_r;
      ram_rd_block_o  <= row_ready_r;
      ram_wr_o        <= ram_wr_req_i && row_wr_ok;
      ram_wr_addr_o   <= ram_wr_addr_i;
      ram_wr_data_o   <= ram_wr_data_i;
      clkreq_o        <= clkreq_r;
    end
  end

  // Information block sender with inter-byte idle spacing.
  // The first byte after a request carries the guard gap only; later bytes
  // carry the inter-byte spacing picked when they are loaded.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_r    <= DKA_TX_IDLE;
      tx_index_r    <= 5'h00;
      tx_len_r      <= 5'h00;
      tx_valid_o    <= 1'b0;
      tx_byte_o     <= 8'h00;
      tx_gap_bits_o <= DKA_GAP_GUARD;
    end else begin
      unique case (tx_state_r)
        DKA_TX_IDLE: begin
          if (info_start) begin
            tx_state_r    <= DKA_TX_SEND;
            tx_len_r      <= (info_full_i ? DKA_INFO_FULL : DKA_INFO_SHORT) - 5'h01;
            tx_index_r    <= 5'h00;
            tx_valid_o    <= 1'b1;
            tx_byte_o     <= DKA_INFO_BLOCK[7:0];
            tx_gap_bits_o <= DKA_GAP_GUARD;
          end
        end
        DKA_TX_SEND: begin
          if (tx_done) begin
            tx_state_r <= DKA_TX_IDLE;
            tx_valid_o <= 1'b0;
          end else if (tx_take) begin
            tx_index_r    <= tx_index_r + 5'h01;
            tx_byte_o     <= DKA_INFO_BLOCK[{tx_index_r[3:0] + 4'h1, 3'h0} +: 8];
            tx_gap_bits_o <= gap_next;
          end
        end
      endcase
    end
  end

  // Sync edge event and the delay option level for the load path.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_event_o             <= 1'b0;
      interbyte_delay_enable_o <= 1'b0;
    end else begin
      sync_event_o             <= sync_rise_i;
      interbyte_delay_enable_o <= control_r[DKA_CTL_DELAY_BIT];
    end
  end

endmodule // dka_access

// ### hw/dka_pkg.sv
// Package for the debug port key access layer: register map, fields, signatures.
// Assumes a 32-bit classic Wishbone register bus with one byte per word.
package dka_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] DKA_IDX_CONTROL    = 4'h2;
  localparam logic [3:0] DKA_IDX_KEY_STATUS = 4'h7;
  localparam logic [3:0] DKA_IDX_RESET_REQ  = 4'h8;
  localparam logic [3:0] DKA_IDX_SYS_CTRL   = 4'ha;
  localparam logic [3:0] DKA_IDX_SYS_STATUS = 4'hb;

  // Field positions.
  localparam int DKA_CTL_DELAY_BIT    = 7;
  localparam int DKA_KEY_ROW_BIT      = 5;
  localparam int DKA_KEY_PROG_BIT     = 4;
  localparam int DKA_KEY_ERASE_BIT    = 3;
  localparam int DKA_SCTL_FINISH_BIT  = 1;
  localparam int DKA_SCTL_CLKREQ_BIT  = 0;
  localparam int DKA_SST_RSTSYS_BIT   = 5;
  localparam int DKA_SST_INSLEEP_BIT  = 4;
  localparam int DKA_SST_PROGRDY_BIT  = 3;
  localparam int DKA_SST_ROWRDY_BIT   = 2;
  localparam int DKA_SST_LOCK_BIT     = 0;

  // Reset values.
  localparam logic [7:0] DKA_CONTROL_RST  = 8'h00;
  localparam logic       DKA_CLKREQ_RST   = 1'b1;

  // Reset request values; the signature value is arbitrary.
  localparam logic [7:0] DKA_RESET_SIGNATURE = 8'h5a;
  localparam logic [7:0] DKA_RESET_RELEASE   = 8'h00;

  // Key activation signatures, least significant byte shifted in first.
  localparam logic [63:0] DKA_SIG_ERASE = 64'h4e564d4572617365;
  localparam logic [63:0] DKA_SIG_PROG  = 64'h4e564d50726f6720;
  localparam logic [63:0] DKA_SIG_ROW   = 64'h4e564d5573267465;
  localparam logic [2:0]  DKA_KEY_LAST  = 3'h7;

  // Information block; byte n at bits [8n+7:8n]. Content values are arbitrary.
  localparam logic [127:0] DKA_INFO_BLOCK = {
    8'h33,                 // Byte 15: debug_osc_frequency.
    8'h20,                 // Byte 14: reserved.
    8'h31, 8'h3a, 8'h44,   // Bytes 13..11: debug_unit_revision.
    8'h31, 8'h3a, 8'h50,   // Bytes 10..8: memctrl_revision.
    8'h20,                 // Byte 7: reserved.
    8'h20, 8'h20, 8'h58, 8'h58, 8'h59, 8'h4d, 8'h46 // Bytes 6..0: family_identifier.
  };
  localparam logic [4:0] DKA_INFO_FULL  = 5'h10;
  localparam logic [4:0] DKA_INFO_SHORT = 5'h08;

  // Idle bits ahead of a byte in a multi-byte answer.
  localparam logic [2:0] DKA_GAP_GUARD  = 3'h0;
  localparam logic [2:0] DKA_GAP_NORMAL = 3'h2;
  localparam logic [2:0] DKA_GAP_EXTRA  = 3'h2;

  // User row window in RAM, in bytes.
  localparam logic [15:0] DKA_ROW_BYTES = 16'h0020;

  // Information block sender states.
  typedef enum logic [1:0] {
    DKA_TX_IDLE = 2'b01,
    DKA_TX_SEND = 2'b10
  } dka_tx_state_t;

endpackage

// ### sim/dka_assertions.sv
// Port checker for the key access layer.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/100ps
module dka_assertions
  import dka_pkg::*;
(
  // Ports watched.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        key_byte_valid_i,
  input wire logic        info_req_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic [2:0]  tx_gap_bits_o,
  input wire logic        tx_ready_i,
  input wire logic        interbyte_delay_enable_o,
  input wire logic        sync_rise_i,
  input wire logic        sync_event_o,
  input wire logic        brownout_force_o,
  input wire logic [2:0]  brownout_level_o,
  input wire logic [2:0]  brownout_fuse_level_i,
  input wire logic        ram_wr_req_i,
  input wire logic [15:0] ram_wr_addr_i,
  input wire logic        ram_wr_o,
  input wire logic        ram_rd_block_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A taken request is answered exactly one cycle later, for one cycle.
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // Answer stream timing and content.
  property p_info_answer; info_req_i && !tx_valid_o |=> tx_valid_o; endproperty
  a_info_answer: assert property (p_info_answer) else $error("no answer");
  property p_first_gap; $rose(tx_valid_o) |-> tx_gap_bits_o == DKA_GAP_GUARD; endproperty
  a_first_gap: assert property (p_first_gap) else $error("first gap");
  property p_first_byte; $rose(tx_valid_o) |-> tx_byte_o == DKA_INFO_BLOCK[7:0]; endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte");
  property p_later_gap;
    tx_valid_o && tx_ready_i ##1 tx_valid_o |-> tx_gap_bits_o ==
      (interbyte_delay_enable_o ? DKA_GAP_NORMAL + DKA_GAP_EXTRA : DKA_GAP_NORMAL);
  endproperty
  a_later_gap: assert property (p_later_gap) else $error("gap");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o); endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_key_quiet; key_byte_valid_i && !tx_valid_o |=> !tx_valid_o; endproperty
  a_key_quiet: assert property (p_key_quiet) else $error("key answered");
  property p_sync; sync_rise_i |=> sync_event_o; endproperty
  a_sync: assert property (p_sync) else $error("sync event");
  property p_brownout;
    brownout_force_o |-> brownout_level_o == brownout_fuse_level_i;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brownout level");
  property p_row_win;
    ram_wr_req_i && ram_rd_block_o && ram_wr_addr_i >= DKA_ROW_BYTES |=> !ram_wr_o;
  endproperty
  a_row_win: assert property (p_row_win) else $error("row write");
  // Main scenarios reached.
  c_info: cover property (tx_valid_o && !tx_ready_i);
  c_brownout: cover property (brownout_force_o);
  c_row: cover property (ram_wr_req_i && ram_rd_block_o);
endmodule // dka_assertions

bind dka_access dka_assertions dka_assertions_inst (.*);

// ### sim/dka_link_model.sv
// Link layer stand-in: takes answer bytes with random stalls and logs them.
// Assumes each answer byte is held until taken.
`timescale 1ns/100ps
module dka_link_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Answer stream.
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic [2:0] tx_gap_i,
  input  wire logic       slow_i,
  output logic            tx_ready_o
);
  logic [7:0] got_b[$];
  logic [2:0] got_g[$];
  // Ready stalls at random when slow; each taken byte is logged with its gap.
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_b.push_back(tx_byte_i);
      got_g.push_back(tx_gap_i);
    end
    tx_ready_o <= !rst_i && (!slow_i || ($urandom % 3 == 0));
  end
endmodule // dka_link_model

// ### sim/tb_top.sv
// Self-checking bench for the key access layer with a link stand-in.
// Assumes a 100 MHz clock and the package constants.
`timescale 1ns/100ps
module tb_top;
  import dka_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, key_start_i, key_byte_valid_i;
  logic info_req_i, info_full_i, tx_valid_o, tx_ready_i, interbyte_delay_enable_o;
  logic sync_rise_i, sync_event_o, lock_i, insleep_i, erase_done_i, row_copy_done_i;
  logic sys_reset_o, erase_start_o, brownout_force_o, sysbus_allow_o, nvm_direct_en_o;
  logic row_copy_req_o, clkreq_o, ram_wr_req_i, ram_wr_o, ram_rd_block_o, link_slow;
  logic [5:2] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] key_byte_i, tx_byte_o, ram_wr_data_i, ram_wr_data_o;
  logic [2:0] tx_gap_bits_o, brownout_fuse_level_i, brownout_level_o;
  logic [15:0] ram_wr_addr_i, ram_wr_addr_o;
  int fails, cmp_count, n_er, n_se, n_cr;

  dka_access dka_access_inst (.*);
  dka_link_model dka_link_model_inst (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
    .tx_byte_i(tx_byte_o), .tx_gap_i(tx_gap_bits_o), .slow_i(link_slow), .tx_ready_o(tx_ready_i));

  // Clock generator.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Pulse counters on design outputs.
  always @(posedge clk_i) begin
    n_er += (erase_start_o === 1'b1);
    n_se += (sync_event_o === 1'b1);
    n_cr += (row_copy_req_o === 1'b1);
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Shifts in a key, least significant byte first.
  task automatic key(input logic [63:0] s);
    @(posedge clk_i);
    key_start_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      key_start_i <= 1'b0;
      key_byte_valid_i <= 1'b1;
      key_byte_i <= s[8*i +: 8];
    end
    @(posedge clk_i);
    key_byte_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  function automatic logic [2:0] exp_gap(input int i, input logic d);
    if (i == 0) return 3'h0;
    return d ? 3'h4 : 3'h2;
  endfunction

  // Requests the information block and compares every byte and gap.
  task automatic info(input logic f, input logic d);
    int n;
    n = f ? 16 : 8;
    dka_link_model_inst.got_b.delete();
    dka_link_model_inst.got_g.delete();
    @(posedge clk_i);
    info_req_i <= 1'b1;
    info_full_i <= f;
    @(posedge clk_i);
    info_req_i <= 1'b0;
    for (int t = 0; t < 500 && dka_link_model_inst.got_b.size() < n; t++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    chk(dka_link_model_inst.got_b.size(), n);
    for (int i = 0; i < n; i++) begin
      chk(dka_link_model_inst.got_b[i], DKA_INFO_BLOCK[8*i +: 8]);
      chk(dka_link_model_inst.got_g[i], exp_gap(i, d));
    end
  endtask

  // One RAM write through the row filter; p says whether it must pass.
  task automatic ram_wr(input logic [15:0] a, input logic p);
    logic [7:0] d;
    d = $urandom;
    @(posedge clk_i);
    ram_wr_req_i <= 1'b1;
    ram_wr_addr_i <= a;
    ram_wr_data_i <= d;
    @(posedge clk_i);
    ram_wr_req_i <= 1'b0;
    @(negedge clk_i);
    chk(ram_wr_o, p);
    if (p) chk({ram_wr_addr_o, ram_wr_data_o}, {a, d});
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog.
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    wrap_up;
  end

  // Main sequence.
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, key_start_i, key_byte_valid_i, info_req_i} = '0;
    {info_full_i, sync_rise_i, insleep_i, erase_done_i, row_copy_done_i, ram_wr_req_i} = '0;
    {wb_adr_i, wb_dat_i, key_byte_i, ram_wr_addr_i, ram_wr_data_i, link_slow} = '0;
    wb_sel_i = 4'h1;
    lock_i = 1'b1;
    void'($urandom(32'hbf7c));
    brownout_fuse_level_i = $urandom;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, DKA_IDX_CONTROL, 8'h00);
    chk(rd, DKA_CONTROL_RST);
    wb(0, DKA_IDX_SYS_CTRL, 8'h00);
    chk(rd, 32'h1);
    chk(clkreq_o, 1'b1);
    wb(1, 4'hf, 8'hff);
    wb(0, 4'hf, 8'h00);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      wb(1, DKA_IDX_CONTROL, {k[1], 7'h0});
      link_slow <= k[0];
      info(k[0], k[1]);
      chk(interbyte_delay_enable_o, k[1]);
    end
    $display("test information block done");
    key(DKA_SIG_ERASE ^ (64'h1 << ($urandom % 64)));
    key(DKA_SIG_PROG);
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h0);
    chk({sysbus_allow_o, brownout_force_o}, 2'b00);
    key(DKA_SIG_ERASE);
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h08);
    chk(n_er, 1);
    chk({brownout_force_o, brownout_level_o}, {1'b1, brownout_fuse_level_i});
    @(posedge clk_i);
    erase_done_i <= 1'b1;
    lock_i <= 1'b0;
    @(posedge clk_i);
    erase_done_i <= 1'b0;
    key(DKA_SIG_PROG);
    key(DKA_SIG_ERASE);
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h18);
    chk(sysbus_allow_o, 1'b1);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_SIGNATURE);
    wb(0, DKA_IDX_SYS_STATUS, 8'h00);
    chk(rd, 32'h20);
    chk(sys_reset_o, 1'b1);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_RELEASE);
    wb(0, DKA_IDX_SYS_STATUS, 8'h00);
    chk(rd, 32'h08);
    chk(nvm_direct_en_o, 1'b1);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_SIGNATURE);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_RELEASE);
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h08);
    chk({sys_reset_o, nvm_direct_en_o}, 2'b00);
    $display("test erase and programming keys done");
    lock_i <= 1'b1;
    insleep_i <= 1'b1;
    key(DKA_SIG_ROW);
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h28);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_SIGNATURE);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_RELEASE);
    wb(0, DKA_IDX_SYS_STATUS, 8'h00);
    chk(rd, 32'h15);
    chk({ram_rd_block_o, sysbus_allow_o}, 2'b11);
    ram_wr(16'h001f, 1'b1);
    ram_wr(16'h0020, 1'b0);
    for (int i = 0; i < 6; i++) begin
      rd = $urandom % 64;
      ram_wr(rd[15:0], rd < 32);
    end
    wb(1, DKA_IDX_SYS_CTRL, 8'h03);
    wb(0, DKA_IDX_SYS_CTRL, 8'h00);
    chk(rd, 32'h03);
    chk(n_cr, 1);
    @(posedge clk_i);
    row_copy_done_i <= 1'b1;
    @(posedge clk_i);
    row_copy_done_i <= 1'b0;
    wb(0, DKA_IDX_SYS_STATUS, 8'h00);
    chk(rd, 32'h11);
    wb(1, DKA_IDX_KEY_STATUS, 8'h20);
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h08);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_SIGNATURE);
    wb(1, DKA_IDX_RESET_REQ, DKA_RESET_RELEASE);
    chk(ram_rd_block_o, 1'b0);
    ram_wr(16'h0040, 1'b1);
    $display("test user row done");
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      sync_rise_i <= 1'b1;
      @(posedge clk_i);
      sync_rise_i <= 1'b0;
      repeat ($urandom % 8) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
    chk(n_se, 20);
    $display("test sync events done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, DKA_IDX_KEY_STATUS, 8'h00);
    chk(rd, 32'h0);
    $display("test port reset done");
    wrap_up;
  end
endmodule // tb_top
